// File: hw/ppmc_top.v
// Overview of operation
// - low byte of capability word always reads code 01h, read-only
// - wake event sets the wake flag regardless of the enable bit
// - writing one clears wake flag, releasing wake pin; writing zero does nothing
// - wake flag resets to zero, or only on power-up when cold wake supported
// - wake pin asserted only while the wake enable bit is set
// - wake enable resets to zero, or only on power-up when cold wake supported
// - measure scale field bits 14:13 read-only zero
// - measure select field bits 12:9 writable, resets zero, selects nothing
// - power state field bits 1:0 requests and reports D0 through D3hot
// - unsupported power state writes complete but leave state unchanged
// - cold wake support set only with aux power sensed and stored bit set
`timescale 1ns/1ps
`default_nettype none
`include "ppmc_map.vh"

module ppmc_top (
    input wire core_clk_in,
    input wire rst_in,
    input wire por_in,
    input wire sw_rst_in,
    input wire aux_power_sense_in,
    input wire stored_cold_wake_in,
    input wire wake_event_in,
    input wire cfg_rd_in,
    input wire cfg_wr_in,
    input wire [7:0] cfg_addr_in,
    input wire [3:0] cfg_be_in,
    input wire [31:0] cfg_wdata_in,
    output wire [31:0] cfg_rdata_out,
    output wire cfg_ack_out,
    output wire pme_out,
    output wire pme_oe_n_out,
    output wire [1:0] power_state_out,
    output wire [3:0] measure_select_out,
    output wire cold_wake_support_out
);

reg [31:0] rdata_ff;
reg [31:0] nxt_rdata;
reg ack_ff;
reg wake_flag_ff;
reg nxt_wake_flag;
reg wake_en_ff;
reg nxt_wake_en;
reg [3:0] select_ff;
reg [3:0] nxt_select;
reg cold_wake_ff;
reg nxt_cold_wake;
reg pme_oe_n_ff;
reg pme_ff;
reg [1:0] state_mirror_ff;

wire [1:0] state_cur;
wire [31:0] lane_mask;
wire [31:0] wr_bits;
wire ctrl_wr;
wire state_wr;
wire hw_rst;
wire wake_rst;

function addr_hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
        addr_hit = (addr[7:2] == ofs[7:2]);
    end
endfunction

// byte enables turn into a per-bit write mask
genvar lane;
generate
    for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
        assign lane_mask[lane*8 +: 8] = {8{cfg_be_in[lane]}};
    end
endgenerate

assign ctrl_wr = cfg_wr_in && addr_hit(cfg_addr_in, `PPMC_OFS_CTRL_STAT);
assign wr_bits = cfg_wdata_in & lane_mask;
assign state_wr = ctrl_wr && cfg_be_in[0];
assign hw_rst = rst_in || por_in;
// sticky wake bits survive ordinary resets only with cold wake support
assign wake_rst = por_in || ((rst_in || sw_rst_in) && !cold_wake_ff);

// power state register with the supported-state filter
ppmc_pwr_state ppmc_pwr_state_inst (
    .core_clk_in(core_clk_in),
    .rst_in(hw_rst || sw_rst_in),
    .wr_in(state_wr),
    .wdata_in(cfg_wdata_in[`PPMC_STATE_MSB:`PPMC_STATE_LSB]),
    .state_out(state_cur)
);

// cold wake support caught while reset is active
always @* begin
    nxt_cold_wake = cold_wake_ff;
    if (hw_rst) begin
        nxt_cold_wake = aux_power_sense_in && stored_cold_wake_in;
    end
end

always @* begin
    nxt_wake_flag = wake_flag_ff;
    if (wake_rst) begin
        nxt_wake_flag = `PPMC_RST_FLAG;
    end else if (wake_event_in) begin
        // a new event beats a same-cycle clear so none is lost
        nxt_wake_flag = 1'b1;
    end else if (ctrl_wr && wr_bits[`PPMC_WAKE_FLAG_BIT]) begin
        nxt_wake_flag = 1'b0;
    end
end

always @* begin
    nxt_wake_en = wake_en_ff;
    if (wake_rst) begin
        nxt_wake_en = 1'b0;
    end else if (ctrl_wr && cfg_be_in[1]) begin
        nxt_wake_en = cfg_wdata_in[`PPMC_WAKE_EN_BIT];
    end
end

always @* begin
    nxt_select = select_ff;
    if (ctrl_wr && cfg_be_in[1]) begin
        // stored only; nothing is reported through it
        nxt_select = cfg_wdata_in[`PPMC_SELECT_MSB:`PPMC_SELECT_LSB];
    end
end

// read mux, registered so data appear with the ack
always @* begin
    nxt_rdata = 32'h00000000;
    if (addr_hit(cfg_addr_in, `PPMC_OFS_CAPS)) begin
        nxt_rdata[7:0] = `PPMC_CAP_CODE;
        nxt_rdata[15:8] = `PPMC_CAP_NEXT_PTR;
        nxt_rdata[18:16] = `PPMC_CAP_VERSION;
        nxt_rdata[24:22] = cold_wake_ff ? `PPMC_CAP_AUX_FULL : `PPMC_CAP_AUX_NONE;
        nxt_rdata[`PPMC_CAP_D1_BIT] = `PPMC_D1_SUPPORTED;
        nxt_rdata[`PPMC_CAP_D2_BIT] = `PPMC_D2_SUPPORTED;
        nxt_rdata[30:27] = `PPMC_CAP_WAKE_STATES;
        nxt_rdata[`PPMC_CAP_COLD_BIT] = cold_wake_ff;
    end else if (addr_hit(cfg_addr_in, `PPMC_OFS_CTRL_STAT)) begin
        // upper half and bits 7:2 stay zero
        nxt_rdata[`PPMC_WAKE_FLAG_BIT] = wake_flag_ff;
        nxt_rdata[`PPMC_SCALE_MSB:`PPMC_SCALE_LSB] = `PPMC_RST_SCALE;
        nxt_rdata[`PPMC_SELECT_MSB:`PPMC_SELECT_LSB] = select_ff;
        nxt_rdata[`PPMC_WAKE_EN_BIT] = wake_en_ff;
        nxt_rdata[`PPMC_STATE_MSB:`PPMC_STATE_LSB] = state_cur;
    end
end

always @(posedge core_clk_in) begin
    cold_wake_ff <= nxt_cold_wake;
    wake_flag_ff <= nxt_wake_flag;
    wake_en_ff <= nxt_wake_en;
    if (hw_rst || sw_rst_in) begin
        select_ff <= `PPMC_RST_SELECT;
        rdata_ff <= 32'h00000000;
        ack_ff <= 1'b0;
        state_mirror_ff <= `PPMC_RST_STATE;
    end else begin
        select_ff <= nxt_select;
        rdata_ff <= cfg_rd_in ? nxt_rdata : 32'h00000000;
        ack_ff <= cfg_rd_in || cfg_wr_in;
        state_mirror_ff <= state_cur;
    end
end

// wake pin: open drain, low-active enable while pulling low
// open drain: the driven value never changes, kept in a flop like every output
always @(posedge core_clk_in) begin
    pme_ff <= 1'b0;
end

always @(posedge core_clk_in) begin
    if (wake_rst) begin
        pme_oe_n_ff <= 1'b1;
    end else begin
        pme_oe_n_ff <= !(nxt_wake_flag && nxt_wake_en);
    end
end

assign cfg_rdata_out = rdata_ff;
assign cfg_ack_out = ack_ff;
assign pme_out = pme_ff;
assign pme_oe_n_out = pme_oe_n_ff;
assign power_state_out = state_mirror_ff;
assign measure_select_out = select_ff;
assign cold_wake_support_out = cold_wake_ff;

endmodule // ppmc_top

`default_nettype wire

// File: shared/ppmc_map.vh
`ifndef PPMC_MAP_VH
`define PPMC_MAP_VH

// configuration space byte offsets
`define PPMC_OFS_CAPS 8'hc0
`define PPMC_OFS_CTRL_STAT 8'hc4

// capability word fields
`define PPMC_CAP_CODE 8'h01
`define PPMC_CAP_NEXT_PTR 8'h00
`define PPMC_CAP_VERSION 3'h2
`define PPMC_CAP_WAKE_STATES 4'hf
`define PPMC_CAP_AUX_FULL 3'h7
`define PPMC_CAP_AUX_NONE 3'h0
`define PPMC_CAP_COLD_BIT 31
`define PPMC_CAP_STATES_LSB 27
`define PPMC_CAP_D2_BIT 26
`define PPMC_CAP_D1_BIT 25
`define PPMC_CAP_AUX_LSB 22
`define PPMC_CAP_VER_LSB 16
`define PPMC_CAP_NEXT_LSB 8

// control-status word fields
`define PPMC_WAKE_FLAG_BIT 15
`define PPMC_SCALE_MSB 14
`define PPMC_SCALE_LSB 13
`define PPMC_SELECT_MSB 12
`define PPMC_SELECT_LSB 9
`define PPMC_WAKE_EN_BIT 8
`define PPMC_STATE_MSB 1
`define PPMC_STATE_LSB 0

// reset values
`define PPMC_RST_SCALE 2'h0
`define PPMC_RST_SELECT 4'h0
`define PPMC_RST_STATE 2'h0
`define PPMC_RST_FLAG 1'h0

// power state encodings
`define PPMC_STATE_D0 2'h0
`define PPMC_STATE_D1 2'h1
`define PPMC_STATE_D2 2'h2
`define PPMC_STATE_D3HOT 2'h3

// which optional states this function accepts
`define PPMC_D1_SUPPORTED 1'h1
`define PPMC_D2_SUPPORTED 1'h1

`endif

// File: hw/ppmc_pwr_state.v
`timescale 1ns/1ps
`default_nettype none
`include "ppmc_map.vh"

module ppmc_pwr_state (
    input wire core_clk_in,
    input wire rst_in,
    input wire wr_in,
    input wire [1:0] wdata_in,
    output wire [1:0] state_out
);

reg [1:0] state_ff;
reg [1:0] nxt_state;

function state_ok;
    input [1:0] s;
    begin
        case (s)
            `PPMC_STATE_D1: state_ok = `PPMC_D1_SUPPORTED;
            `PPMC_STATE_D2: state_ok = `PPMC_D2_SUPPORTED;
            default: state_ok = 1'b1;
        endcase
    end
endfunction

always @* begin
    nxt_state = state_ff;
    // unsupported request: bus cycle still completes, value dropped
    if (wr_in && state_ok(wdata_in)) begin
        nxt_state = wdata_in;
    end
end

always @(posedge core_clk_in) begin
    if (rst_in) begin
        state_ff <= `PPMC_RST_STATE;
    end else begin
        state_ff <= nxt_state;
    end
end

assign state_out = state_ff;

endmodule // ppmc_pwr_state

`default_nettype wire

// File: verif/ppmc_host_pin.sv
`timescale 1ns/1ps
`default_nettype none
module ppmc_host_pin (
    input wire logic pme_out,
    input wire logic pme_oe_n_out,
    output logic pme_wire_out
);
    // board pull-up holds the released wake line high
    assign pme_wire_out = pme_oe_n_out ? 1'b1 : pme_out;
endmodule // ppmc_host_pin
`default_nettype wire

// File: verif/ppmc_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ppmc_chk (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic por_in,
    input wire logic sw_rst_in,
    input wire logic wake_event_in,
    input wire logic cfg_rd_in,
    input wire logic cfg_wr_in,
    input wire logic [7:0] cfg_addr_in,
    input wire logic [3:0] cfg_be_in,
    input wire logic [31:0] cfg_wdata_in,
    input wire logic [31:0] cfg_rdata_out,
    input wire logic cfg_ack_out,
    input wire logic pme_out,
    input wire logic pme_oe_n_out,
    input wire logic [1:0] power_state_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in || por_in || sw_rst_in);
    wire logic cs = cfg_addr_in[7:2] == 6'h31;
    a_ack_after_req: assert property ((cfg_rd_in || cfg_wr_in) |=> cfg_ack_out)
        else $error("ack missing");
    a_ack_no_req: assert property (!(cfg_rd_in || cfg_wr_in) |=> !cfg_ack_out)
        else $error("ack without request");
    a_cap_code_fixed: assert property (cfg_rd_in && cfg_addr_in[7:2] == 6'h30
        |=> cfg_rdata_out[7:0] == 8'h01) else $error("capability code wrong");
    a_resv_bits_zero: assert property (cfg_rd_in && cs |=> cfg_rdata_out[31:16] == 16'h0
        && cfg_rdata_out[14:13] == 2'h0 && cfg_rdata_out[7:2] == 6'h0) else $error("resv");
    a_idle_rdata_zero: assert property (!cfg_ack_out |-> cfg_rdata_out == 32'h0)
        else $error("read data outside ack");
    a_state_follows: assert property (cfg_wr_in && cs && cfg_be_in[0]
        |=> ##1 power_state_out == $past(cfg_wdata_in[1:0], 2)) else $error("state");
    a_flag_clear_release: assert property (cfg_wr_in && cs && cfg_be_in[1]
        && cfg_wdata_in[15] && !wake_event_in |=> pme_oe_n_out) else $error("clear");
    a_enable_off_release: assert property (cfg_wr_in && cs && cfg_be_in[1]
        && !cfg_wdata_in[8] |=> pme_oe_n_out) else $error("enable off");
    a_pme_needs_cause: assert property ($fell(pme_oe_n_out)
        |-> $past(wake_event_in) || $past(cfg_wr_in)) else $error("pme without cause");
endmodule // ppmc_chk
`default_nettype wire

// File: verif/test_pci_power_mgmt_control_status.sv
`timescale 1ns/1ps
`default_nettype none
module test_pci_power_mgmt_control_status;
    logic clk = 0, rst = 1, por = 1, swr = 0, aux = 0, sto = 0, wev = 0, rd = 0, wr = 0;
    logic [7:0] addr = 8'h0;
    logic [3:0] be = 4'h0;
    logic [31:0] wd = 32'h0, rdat;
    logic ack, pme, oen, cold, pin;
    logic [1:0] pst;
    logic [3:0] sel;
    int errors = 0, samples_checked = 0, cyc = 0;
    ppmc_top ppmc_top_inst (.core_clk_in(clk), .rst_in(rst), .por_in(por), .sw_rst_in(swr),
        .aux_power_sense_in(aux), .stored_cold_wake_in(sto), .wake_event_in(wev),
        .cfg_rd_in(rd), .cfg_wr_in(wr), .cfg_addr_in(addr), .cfg_be_in(be),
        .cfg_wdata_in(wd), .cfg_rdata_out(rdat), .cfg_ack_out(ack), .pme_out(pme),
        .pme_oe_n_out(oen), .power_state_out(pst), .measure_select_out(sel),
        .cold_wake_support_out(cold));
    ppmc_host_pin ppmc_host_pin_inst (.pme_out(pme), .pme_oe_n_out(oen), .pme_wire_out(pin));
    initial forever #12.5 clk = ~clk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results;
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic wrc(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
        @(negedge clk);
        wr = 1;
        addr = a;
        be = b;
        wd = d;
        @(negedge clk);
        wr = 0;
        chk(ack, 1);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        @(negedge clk);
        rd = 1;
        addr = a;
        @(negedge clk);
        rd = 0;
        chk(ack, 1);
        chk(rdat, exp);
    endtask
    task automatic ev;
        @(negedge clk);
        wev = 1;
        @(negedge clk);
        wev = 0;
    endtask
    // short mid-run resets; one edge is enough for a synchronous clear
    task automatic rstp(input logic h, input logic p, input logic s);
        @(negedge clk);
        rst = h;
        por = p;
        swr = s;
        repeat (2) @(negedge clk);
        rst = 0;
        por = 0;
        swr = 0;
    endtask
    initial begin
        repeat (16) @(negedge clk);
        rst = 0;
        por = 0;
        chk(cold, 0);
        rdc(8'hc0, 32'h7e020001);
        rdc(8'hc4, 32'h0);
        wrc(8'hc0, 4'hf, 32'h0);
        rdc(8'hc0, 32'h7e020001);
        rdc(8'h00, 32'h0);
        wrc(8'hc4, 4'hf, 32'hffffffff);
        rdc(8'hc4, 32'h1f03);
        chk(sel, 4'hf);
        for (int s = 0; s < 4; s++) begin
            wrc(8'hc4, 4'h1, s);
            rdc(8'hc4, 32'h1f00 | s);
            chk(pst, s);
        end
        ev;
        chk(pin, 0);
        rdc(8'hc4, 32'h9f03);
        wrc(8'hc4, 4'h2, 32'h1f00);
        rdc(8'hc4, 32'h9f03);
        wrc(8'hc4, 4'h2, 32'h9f00);
        chk(pin, 1);
        wrc(8'hc4, 4'h2, 32'h1e00);
        ev;
        chk(pin, 1);
        rdc(8'hc4, 32'h9e03);
        rstp(0, 0, 1);
        rdc(8'hc4, 32'h0);
        aux = 1;
        sto = 1;
        rstp(1, 0, 0);
        chk(cold, 1);
        rdc(8'hc0, 32'hffc20001);
        wrc(8'hc4, 4'h2, 32'h0100);
        ev;
        rstp(1, 0, 0);
        rdc(8'hc4, 32'h8100);
        chk(pin, 0);
        rstp(0, 1, 0);
        rdc(8'hc4, 32'h0);
        results;
    end
    // whole run is under a hundred cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            errors++;
            results;
        end
    end
endmodule // test_pci_power_mgmt_control_status
bind ppmc_top ppmc_chk ppmc_chk_inst (.core_clk_in, .rst_in, .por_in, .sw_rst_in,
    .wake_event_in, .cfg_rd_in, .cfg_wr_in, .cfg_addr_in, .cfg_be_in, .cfg_wdata_in,
    .cfg_rdata_out, .cfg_ack_out, .pme_out, .pme_oe_n_out, .power_state_out);
`default_nettype wire
